// >>> hw/pasm_map.svh
// Constants for the program address segment map
`ifndef PASM_MAP_SVH
`define PASM_MAP_SVH

// ****************************************
// Segment boundaries and address math
// ****************************************
`define PASM_ADDR_W 32
`define PASM_MSB 31
`define PASM_SEG_HI 31
`define PASM_SEG_LO 29
`define PASM_DIRECT_MASK 32'h1fff_ffff
`define PASM_CACHED_CLR 32'h7fff_ffff
`define PASM_USER_OFFSET 32'h4000_0000
`define PASM_RESET_VECTOR 32'hbfc0_0000
`define PASM_RESET_PHYS 32'h1fc0_0000

`endif

// >>> hw/pasm_pkg.sv
// Types for the program address segment map
package pasm_pkg;

   // ****************************************
   // Segment codes
   // ****************************************
   typedef enum logic [1:0] {
      PASM_SEG_USER = 2'b00,
      PASM_SEG_CACHED_DIRECT = 2'b01,
      PASM_SEG_UNCACHED_DIRECT = 2'b10,
      PASM_SEG_KERNEL_HIGH = 2'b11
   } pasm_seg_e;

   // Request from the core
   typedef struct packed {
      logic valid;
      logic fetch;
      logic write;
      logic [31:0] addr;
   } pasm_req_s;

   // Access presented to memory
   typedef struct packed {
      logic valid;
      logic fetch;
      logic write;
      logic cached;
      logic [31:0] paddr;
   } pasm_mem_s;

   // Trap report to the exception logic
   typedef struct packed {
      logic addr_trap;
      logic instr_trap;
      logic [31:0] bad_addr;
   } pasm_trap_s;

endpackage

// >>> hw/pasm_decode.sv
// Combinational segment decode of one program address
`timescale 1ns/1ns
`include "pasm_map.svh"

module pasm_decode #(
   parameter bit HAS_XLATE = 1'b0
) (
   input wire logic [31:0] addr,
   input wire logic user_mode,
   output pasm_pkg::pasm_seg_e seg,
   output logic [31:0] paddr,
   output logic cached,
   output logic illegal
);

   // ****************************************
   // Segment select and physical address
   // ****************************************
   always_comb begin
      seg = pasm_pkg::PASM_SEG_USER;
      paddr = addr;
      cached = 1'b0;
      illegal = user_mode && addr[`PASM_MSB];
      if (!addr[`PASM_MSB]) begin
         seg = pasm_pkg::PASM_SEG_USER;
         // User segment: fixed offset without translation hardware
         paddr = HAS_XLATE ? addr : addr + `PASM_USER_OFFSET;
         cached = 1'b1;
      end else if (addr[30:29] == 2'b00) begin
         seg = pasm_pkg::PASM_SEG_CACHED_DIRECT;
         paddr = addr & `PASM_CACHED_CLR;
         cached = 1'b1;
      end else if (addr[30:29] == 2'b01) begin
         seg = pasm_pkg::PASM_SEG_UNCACHED_DIRECT;
         paddr = addr & `PASM_DIRECT_MASK;
         cached = 1'b0;
      end else begin
         seg = pasm_pkg::PASM_SEG_KERNEL_HIGH;
         paddr = addr;
         cached = 1'b1;
      end
   end

endmodule // pasm_decode

// >>> hw/pasm_segment_map.sv
// Program address segment map: privilege check, cache select, physical address
// How it works
// - In user mode any address with bit 31 set is illegal and traps instead of accessing.
// - Addresses 0 to 0x7fff_ffff are the user segment, the only one legal in user mode.
// - Without translation hardware a user address gains a one gigabyte offset.
// - Addresses 0x8000_0000 to 0x9fff_ffff map to physical by clearing bit 31.
// - The cached direct segment is always accessed through the cache.
// - Addresses 0xa000_0000 to 0xbfff_ffff map to physical by clearing bits 31 to 29.
// - The uncached direct segment always bypasses the cache.
// - After reset fetch starts at 0xbfc0_0000, physical 0x1fc0_0000.
// - The kernel high segment 0xc000_0000 up is kernel only; user access traps.
// - Without translation hardware the kernel high segment passes unchanged.
// - Reset enters kernel mode, where all four segments are legal.
// - Privileged instructions executed in user mode trap.
`timescale 1ns/1ns
`include "pasm_map.svh"

module pasm_segment_map #(
   parameter bit HAS_XLATE = 1'b0
) (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire pasm_pkg::pasm_req_s REQ,
   input wire logic PRIV_INSTR,
   input wire logic MODE_WE,
   input wire logic MODE_USER,
   output pasm_pkg::pasm_mem_s MEM,
   output pasm_pkg::pasm_trap_s TRAP,
   output logic USER_MODE,
   output logic [31:0] BOOT_PC
);

   pasm_pkg::pasm_seg_e seg;
   logic [31:0] paddr;
   logic cached;
   logic illegal;
   logic pass_req;
   logic user_reg, user_next;
   pasm_pkg::pasm_mem_s mem_reg, mem_next;
   pasm_pkg::pasm_trap_s trap_reg, trap_next;
   logic [31:0] boot_pc_reg, boot_pc_next;

   // ****************************************
   // Address decode
   // ****************************************
   pasm_decode #(
      .HAS_XLATE(HAS_XLATE)
   ) u_decode (
      .addr(REQ.addr),
      .user_mode(user_reg),
      .seg(seg),
      .paddr(paddr),
      .cached(cached),
      .illegal(illegal)
   );

   // ****************************************
   // Request qualifier
   // ****************************************
   // Only a valid and legal request reaches memory
   always_comb begin
      pass_req = REQ.valid && !illegal;
   end

   // ****************************************
   // Privilege mode
   // ****************************************
   // Mode changes only on an explicit load
   always_comb begin
      user_next = user_reg;
      if (MODE_WE) begin
         user_next = MODE_USER;
      end
   end

   // Reset forces kernel mode
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         user_reg <= 1'b0;
      end else begin
         user_reg <= user_next;
      end
   end

   // ****************************************
   // Memory access
   // ****************************************
   // Legal requests go to memory one cycle later
   always_comb begin
      mem_next = '0;
      if (pass_req) begin
         mem_next.valid = 1'b1;
         mem_next.fetch = REQ.fetch;
         mem_next.write = REQ.write;
         mem_next.cached = cached;
         mem_next.paddr = paddr;
      end
   end

   // Access register; nothing goes out during reset
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mem_reg <= '0;
      end else begin
         mem_reg <= mem_next;
      end
   end

   // ****************************************
   // Trap report
   // ****************************************
   // Illegal addresses and user privileged instructions
   always_comb begin
      trap_next = '0;
      if (REQ.valid && illegal) begin
         // Kernel high and both direct segments trap in user mode
         trap_next.addr_trap = 1'b1;
         trap_next.bad_addr = REQ.addr;
      end
      trap_next.instr_trap = PRIV_INSTR && user_reg;
   end

   // Trap register; flags stand one cycle
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         trap_reg <= '0;
      end else begin
         trap_reg <= trap_next;
      end
   end

   // ****************************************
   // Reset fetch address
   // ****************************************
   // Boot address holds its reset value
   always_comb begin
      boot_pc_next = boot_pc_reg;
   end

   // Reset loads the uncached boot vector
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         boot_pc_reg <= `PASM_RESET_VECTOR;
      end else begin
         boot_pc_reg <= boot_pc_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Every output comes from a register
   assign MEM = mem_reg;
   assign TRAP = trap_reg;
   assign USER_MODE = user_reg;
   assign BOOT_PC = boot_pc_reg;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);

   // Request shapes by mode and segment
   sequence s_user_high;
      REQ.valid && user_reg && REQ.addr[31];
   endsequence

   sequence s_user_low;
      REQ.valid && user_reg && !REQ.addr[31];
   endsequence

   sequence s_any_low;
      REQ.valid && !REQ.addr[31];
   endsequence

   sequence s_low_no_xlate;
      REQ.valid && !REQ.addr[31] && !HAS_XLATE;
   endsequence

   sequence s_kernel_req;
      REQ.valid && !user_reg;
   endsequence

   sequence s_kernel_cached;
      REQ.valid && !user_reg && REQ.addr[31:29] == 3'b100;
   endsequence

   sequence s_kernel_uncached;
      REQ.valid && !user_reg && REQ.addr[31:29] == 3'b101;
   endsequence

   sequence s_kernel_high;
      REQ.valid && !user_reg && REQ.addr[31:30] == 2'b11;
   endsequence

   sequence s_user_top;
      REQ.valid && user_reg && REQ.addr[31:30] == 2'b11;
   endsequence

   sequence s_boot_fetch;
      REQ.valid && !user_reg && REQ.addr == `PASM_RESET_VECTOR;
   endsequence

   // Outcomes one cycle after a request
   sequence s_trapped;
      TRAP.addr_trap && !MEM.valid;
   endsequence

   sequence s_performed;
      MEM.valid && !TRAP.addr_trap;
   endsequence

   sequence s_quiet;
      !MEM.valid && !TRAP.addr_trap && TRAP.bad_addr == 32'h0;
   endsequence

   // Segment codes
   chk_seg_user: assert property (
      s_any_low |-> seg == pasm_pkg::PASM_SEG_USER)
      else $error("user segment code wrong");

   chk_seg_cached: assert property (
      s_kernel_cached |-> seg == pasm_pkg::PASM_SEG_CACHED_DIRECT)
      else $error("cached segment code wrong");

   chk_seg_uncached: assert property (
      s_kernel_uncached |-> seg == pasm_pkg::PASM_SEG_UNCACHED_DIRECT)
      else $error("uncached segment code wrong");

   chk_seg_high: assert property (
      s_kernel_high |-> seg == pasm_pkg::PASM_SEG_KERNEL_HIGH)
      else $error("kernel high segment code wrong");

   // Address map
   chk_user_seg_ok: assert property (
      s_any_low |=> s_performed)
      else $error("user segment access dropped");

   chk_user_legal: assert property (
      s_user_low |=> s_performed)
      else $error("user mode low access trapped");

   chk_user_offset: assert property (
      s_low_no_xlate |=> MEM.paddr == $past(REQ.addr) + `PASM_USER_OFFSET)
      else $error("user offset wrong");

   chk_cached_map: assert property (
      s_kernel_cached |=> MEM.cached && MEM.paddr == {1'b0, $past(REQ.addr[30:0])})
      else $error("cached direct map wrong");

   chk_uncached_map: assert property (
      s_kernel_uncached |=> !MEM.cached && MEM.paddr == {3'b000, $past(REQ.addr[28:0])})
      else $error("uncached direct map wrong");

   chk_boot_phys: assert property (
      s_boot_fetch |=> MEM.paddr == `PASM_RESET_PHYS && !MEM.cached)
      else $error("boot vector map wrong");

   chk_kernel_high: assert property (
      s_kernel_high |=> MEM.valid && MEM.paddr == $past(REQ.addr))
      else $error("kernel high map wrong");

   chk_fields_pass: assert property (
      s_kernel_req |=> MEM.fetch == $past(REQ.fetch) && MEM.write == $past(REQ.write))
      else $error("access kind not passed on");

   // Privilege and traps
   chk_user_high_trap: assert property (
      s_user_high |=> s_trapped)
      else $error("user high access not trapped");

   chk_user_top_trap: assert property (
      s_user_top |=> s_trapped)
      else $error("user kernel high access not trapped");

   chk_kernel_legal: assert property (
      s_kernel_req |=> !TRAP.addr_trap)
      else $error("kernel access trapped");

   chk_mode_load: assert property (
      MODE_WE |=> USER_MODE == $past(MODE_USER))
      else $error("mode not loaded");

   chk_mode_hold: assert property (
      !MODE_WE |=> USER_MODE == $past(USER_MODE))
      else $error("mode changed without load");

   chk_priv_instr: assert property (
      PRIV_INSTR && user_reg |=> TRAP.instr_trap)
      else $error("privileged instruction not trapped");

   chk_instr_quiet: assert property (
      !(PRIV_INSTR && user_reg) |=> !TRAP.instr_trap)
      else $error("spurious instruction trap");

   chk_bad_addr: assert property (
      s_user_high |=> TRAP.bad_addr == $past(REQ.addr))
      else $error("bad address not reported");

   chk_idle_quiet: assert property (
      !REQ.valid |=> s_quiet)
      else $error("output without request");

endmodule // pasm_segment_map

// >>> verification/pasm_boot_mem.sv
// Boot memory model on the memory side of the map
`timescale 1ns/1ns
module pasm_boot_mem (
   input wire logic clk,
   input wire pasm_pkg::pasm_mem_s mem,
   output logic boot_hit
);
   // Boot memory answers a fetch at the reset location one cycle later
   always_ff @(posedge clk) begin
      boot_hit <= mem.valid && mem.fetch && (mem.paddr === 32'h1fc0_0000);
   end
endmodule // pasm_boot_mem

// >>> verification/pasm_segment_map_bench.sv
// Self-checking bench of the program address segment map
`timescale 1ns/1ns
module pasm_segment_map_bench;
   // ****************************************
   // Signals and instances
   // ****************************************
   logic clk = 0, arst_n = 0, priv = 0, mode_we = 0, mode_user = 0, boot_hit, user_mode;
   logic [31:0] boot_pc, lfsr = 32'h16af;
   pasm_pkg::pasm_req_s req = '0;
   pasm_pkg::pasm_mem_s mem;
   pasm_pkg::pasm_trap_s trap;
   int bad_count = 0, total_checks = 0;
   logic [31:0] corners[9] = '{32'h0, 32'h7fff_ffff, 32'h8000_0000, 32'h9fff_ffff,
      32'ha000_0000, 32'hbfc0_0000, 32'hbfff_ffff, 32'hc000_0000, 32'hffff_ffff};

   // Clock of 10 ns
   always #5 clk = ~clk;

   pasm_segment_map uut (.CLK(clk), .ARST_N(arst_n), .REQ(req), .PRIV_INSTR(priv),
      .MODE_WE(mode_we), .MODE_USER(mode_user), .MEM(mem), .TRAP(trap),
      .USER_MODE(user_mode), .BOOT_PC(boot_pc));
   pasm_boot_mem boot (.clk(clk), .mem(mem), .boot_hit(boot_hit));

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] next_rand(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   // Expected physical address
   function automatic logic [31:0] exp_pa(logic [31:0] a);
      if (!a[31]) return a + 32'h4000_0000;
      if (!a[30]) return a & 32'h1fff_ffff;
      return a;
   endfunction

   task automatic check(logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic reset_dut();
      arst_n = 0;
      repeat (4) @(posedge clk);
      #1 arst_n = 1;
   endtask

   // Load mode, issue one request, check its answer one cycle later
   task automatic access(logic u, logic pi, logic [31:0] a);
      logic bad;
      bad = u & a[31];
      @(posedge clk);
      #1 mode_we = 1;
      mode_user = u;
      @(posedge clk);
      #1 mode_we = 0;
      req = '{1'b1, !a[1], a[0], a};
      priv = pi;
      @(posedge clk);
      #1 req.valid = 0;
      priv = 0;
      check(user_mode, u);
      check(mem.valid, !bad);
      check(trap.addr_trap, bad);
      check(trap.bad_addr, bad ? a : 32'h0);
      check(trap.instr_trap, u & pi);
      if (!bad) begin
         check(mem.paddr, exp_pa(a));
         check(mem.cached, a[31:29] != 3'h5);
         check(mem.fetch, !a[1]);
         check(mem.write, a[0]);
      end
   endtask

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      reset_dut();
      check(boot_pc, 32'hbfc0_0000);
      access(0, 0, 32'hbfc0_0000);
      @(posedge clk);
      #1 check(boot_hit, 1);
      $display("boot test done");
      foreach (corners[i]) begin
         for (int m = 0; m < 4; m++) begin
            access(m[0], m[1], corners[i]);
         end
      end
      $display("corner test done");
      repeat (40) begin
         lfsr = next_rand(lfsr);
         access(lfsr[7], lfsr[3], lfsr);
      end
      $display("random test done");
      reset_dut();
      check(user_mode, 0);
      check(mem.valid, 0);
      check(boot_pc, 32'hbfc0_0000);
      $display("reset test done");
      give_verdict();
   end

   // Watchdog
   initial begin
      #20000;
      bad_count++;
      give_verdict();
   end
endmodule // pasm_segment_map_bench
